/* icc_bus_model.sv */
// pulled-up two-wire bus with a second master that issues conditions
`timescale 1ns/1ps
`default_nettype none
module icc_bus_model (
  // device pin drives
  input  wire logic scl_oe,
  input  wire logic sda_oe,
  // wired levels seen by the device
  output wire logic scl_i,
  output wire logic sda_i
);
  logic scl_low = 1'b0;
  logic sda_low = 1'b0;
  // any party pulling low wins, otherwise the pull-up holds the line high
  assign scl_i = !(scl_oe || scl_low);
  assign sda_i = !(sda_oe || sda_low);
  // start: data falls under a high clock, then the clock is parked low
  task automatic start_cond();
    sda_low = 1'b1;
    #32 scl_low = 1'b1;
  endtask
  // stop: clock released first, data rises under it; clock then stands still
  task automatic stop_cond();
    #32 scl_low = 1'b0;
    #32 sda_low = 1'b0;
  endtask
endmodule
`default_nettype wire

/* icc_ctrl.sv */
// condition, bit count and interrupt control slice of a two-wire serial interface
//
// How it works
// - in bus format a falling data line with clock high sets busy
// - in bus format a rising data line with clock high clears busy
// - master write busy=1 with inhibit=0 issues a start or repeated start
// - master write busy=0 with inhibit=0 issues a stop
// - in synchronous format the busy flag does nothing
// - start/stop inhibit reads 1, reset 1, writing 1 stores nothing
// - data line value changes only when its guard is written 0; guard reads 1
// - data value reads the driven level; 0 drives low, 1 releases
// - a read-only bit shows the clock line output level
// - control reset bit resets the engine, not registers
// - bit order 0 is msb first, 1 lsb first; keep 0 in bus format
// - bus master with wait holds clock low two transfer clocks before ack
// - wait setting ignored as slave and in synchronous format
// - counter sets next transfer length and reads the bits still remaining
// - bus 000=9, 001..111=2..8 bits; sync 000=8, 001..111=1..7 bits
// - counter returns to 000 at the end of each transfer
// - tx empty request is tx empty flag and its enable
// - tx end request follows tx end flag and its enable
// - rx full request on flag and enable; sync format also raises overrun
// - nack request on nack or arbitration lost; sync overrun also via it
// - master and transmit select pick slave rx/tx, master rx/tx
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "icc_regs.svh"

module icc_ctrl
  import icc_pkg::*;
#(
  parameter int HALF_CYC = `ICC_SCL_HALF_CYC
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       reset_n,
  // register port
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output var  logic [7:0] reg_rdata,
  // data path
  input  wire logic       xfer_go,
  input  wire logic [7:0] tx_byte,
  output var  logic [7:0] rx_byte,
  output var  logic       xfer_done,
  input  wire icc_flags_s flags,
  output var  icc_irq_s   irq,
  // serial pins
  input  wire logic       scl_i,
  output var  logic       scl_o,
  output var  logic       scl_oe,
  input  wire logic       sda_i,
  output var  logic       sda_o,
  output var  logic       sda_oe
);

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------
  // counter field to total bits of the transfer
  function automatic logic [3:0] count_total(input logic sync, input logic [2:0] f);
    logic [3:0] t;
    t = {1'b0, f};
    if (sync) begin
      count_total = (f == 3'h0) ? 4'h8 : t;
    end else begin
      count_total = (f == 3'h0) ? 4'h9 : t + 4'h1;
    end
  endfunction

  // remaining bits back to the counter field encoding
  function automatic logic [2:0] count_field(input logic sync, input logic [3:0] n);
    logic [3:0] m;
    m = n - 4'h1;
    count_field = sync ? n[2:0] : m[2:0];
  endfunction

  // ---------------------------------------------------------------
  // registers and state
  // ---------------------------------------------------------------
  icc_state_e  state;
  icc_state_e  next_state;
  logic [2:0]  scl_sy;
  logic [2:0]  sda_sy;
  logic        scl_f;
  logic        sda_f;
  logic        scl_prev;
  logic        sda_prev;
  logic        busy;
  logic        sda_val;
  logic        ctrl_rst;
  logic        bit_order;
  logic        wait_en;
  logic [2:0]  count;
  logic [7:0]  irq_en;
  logic [7:0]  op_mode;
  logic        start_pend;
  logic        stop_pend;
  logic [15:0] div;
  logic [1:0]  wcnt;
  logic [3:0]  left;
  logic [7:0]  sh;

  // ---------------------------------------------------------------
  // decoding
  // ---------------------------------------------------------------
  wire       sync_fmt  = op_mode[`ICC_OM_SYNC_FMT];
  wire       master    = op_mode[`ICC_OM_MASTER];
  wire       transmit  = op_mode[`ICC_OM_TRANSMIT];
  wire       wr_cond   = reg_wr && (reg_addr == `ICC_OFS_COND);
  wire       wr_xmode  = reg_wr && (reg_addr == `ICC_OFS_XMODE);
  wire       wr_irqen  = reg_wr && (reg_addr == `ICC_OFS_IRQEN);
  wire       wr_opmode = reg_wr && (reg_addr == `ICC_OFS_OPMODE);
  // a condition request needs inhibit written 0, master mode and bus format
  wire       cond_req  = wr_cond && !reg_wdata[`ICC_COND_INHIBIT] && master && !sync_fmt;
  wire       start_wr  = cond_req && reg_wdata[`ICC_COND_BUSY];
  wire       stop_wr   = cond_req && !reg_wdata[`ICC_COND_BUSY];
  wire       sda_wr    = wr_cond && !reg_wdata[`ICC_COND_SDA_GUARD];
  wire       cnt_wr    = wr_xmode && !reg_wdata[`ICC_XM_CNT_GUARD];
  // the first stage of each synchroniser is read only by the second
  wire       scl_agree = (scl_sy[1] == scl_sy[2]);
  wire       sda_agree = (sda_sy[1] == sda_sy[2]);
  wire       start_det = scl_f && sda_prev && !sda_f;
  wire       stop_det  = scl_f && !sda_prev && sda_f;
  wire       scl_rise  = scl_f && !scl_prev;
  wire       tick      = (div == 16'h0);
  wire       in_xfer   = (state == ST_BIT_L) || (state == ST_BIT_H) ||
                         (state == ST_WAIT) || (state == ST_SLAVE);
  wire       is_ack    = !sync_fmt && (left == 4'h1);
  wire       cur_bit   = bit_order ? sh[0] : sh[7];
  // wait only for a bus format master, after the last data bit
  wire       use_wait  = wait_en && master && !sync_fmt;
  wire       bit_edge  = ((state == ST_BIT_H) && tick && scl_f) ||
                         ((state == ST_SLAVE) && scl_rise && (left != 4'h0));
  wire [3:0] left_dec  = left - 4'h1;
  wire       last_bit  = bit_edge && (left == 4'h1);
  wire [7:0] next_sh   = bit_order ? {sda_f, sh[7:1]} : {sh[6:0], sda_f};
  wire [2:0] cnt_read  = in_xfer ? count_field(sync_fmt, left) : count;
  wire       div_load  = tick || (state != next_state) ||
                         ((state == ST_BIT_H) && !scl_f);

  // data line level wanted by the engine during a bit
  logic bit_level;
  assign bit_level = is_ack ? transmit : (transmit ? cur_bit : 1'b1);

  // engine drive levels, 1 means released
  logic scl_eng;
  logic sda_eng;
  always_comb begin
    scl_eng = 1'b1;
    sda_eng = 1'b1;
    case (state)
      ST_STA_A: sda_eng = 1'b0;
      ST_STA_B: begin
        scl_eng = 1'b0;
        sda_eng = 1'b0;
      end
      ST_HOLD:  scl_eng = 1'b0;
      ST_BIT_L: begin
        scl_eng = 1'b0;
        sda_eng = bit_level;
      end
      ST_BIT_H: sda_eng = bit_level;
      ST_WAIT: begin
        scl_eng = 1'b0;
        sda_eng = bit_level;
      end
      ST_RS_A:  scl_eng = 1'b0;
      ST_STO_A: begin
        scl_eng = 1'b0;
        sda_eng = 1'b0;
      end
      ST_STO_B: sda_eng = 1'b0;
      ST_SLAVE: sda_eng = bit_level;
      default: begin
        scl_eng = 1'b1;
        sda_eng = 1'b1;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // engine next state
  // ---------------------------------------------------------------
  // the manual data value is and-ed in at the pin, so the engine never has to know it
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start_pend) begin
          next_state = ST_STA_A;
        end else if (xfer_go) begin
          next_state = master ? ST_BIT_L : ST_SLAVE;
        end
      end
      ST_STA_A: if (tick) next_state = ST_STA_B;
      ST_STA_B: if (tick) next_state = ST_HOLD;
      ST_HOLD: begin
        if (start_pend) begin
          next_state = ST_RS_A;
        end else if (stop_pend) begin
          next_state = ST_STO_A;
        end else if (xfer_go) begin
          next_state = ST_BIT_L;
        end
      end
      ST_BIT_L: if (tick) next_state = ST_BIT_H;
      ST_BIT_H: begin
        if (bit_edge) begin
          if (left == 4'h1) begin
            next_state = sync_fmt ? ST_IDLE : ST_HOLD;
          end else if (use_wait && (left == 4'h2)) begin
            next_state = ST_WAIT;
          end else begin
            next_state = ST_BIT_L;
          end
        end
      end
      ST_WAIT:  if (tick && (wcnt == `ICC_WAIT_HALVES)) next_state = ST_BIT_L;
      ST_RS_A:  if (tick) next_state = ST_RS_B;
      ST_RS_B:  if (tick) next_state = ST_STA_A;
      ST_STO_A: if (tick) next_state = ST_STO_B;
      ST_STO_B: if (tick) next_state = ST_IDLE;
      ST_SLAVE: if (last_bit) next_state = ST_IDLE;
      default:  next_state = ST_IDLE;
    endcase
    if (ctrl_rst) begin
      next_state = ST_IDLE;
    end
  end

  // ---------------------------------------------------------------
  // pin synchronisers and filtered levels
  // ---------------------------------------------------------------
  // a change counts only once stages two and three agree, which rejects one-cycle glitches
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      scl_sy   <= 3'h7;
      sda_sy   <= 3'h7;
      scl_f    <= 1'b1;
      sda_f    <= 1'b1;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_sy   <= {scl_sy[1:0], scl_i};
      sda_sy   <= {sda_sy[1:0], sda_i};
      scl_f    <= scl_agree ? scl_sy[2] : scl_f;
      sda_f    <= sda_agree ? sda_sy[2] : sda_f;
      scl_prev <= scl_f;
      sda_prev <= sda_f;
    end
  end

  // bus busy follows observed conditions; it has no meaning in synchronous format
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      busy <= 1'b0;
    end else if (sync_fmt) begin
      busy <= 1'b0;
    end else if (start_det) begin
      busy <= 1'b1;
    end else if (stop_det) begin
      busy <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  // control reset leaves all of these alone
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sda_val   <= `ICC_RST_SDA_VAL;
      ctrl_rst  <= 1'b0;
      bit_order <= 1'b0;
      wait_en   <= 1'b0;
      irq_en    <= `ICC_RST_IRQEN;
      op_mode   <= `ICC_RST_OPMODE;
    end else begin
      if (sda_wr) sda_val <= reg_wdata[`ICC_COND_SDA_VAL];
      if (wr_cond) ctrl_rst <= reg_wdata[`ICC_COND_CTRL_RST];
      if (wr_xmode) bit_order <= reg_wdata[`ICC_XM_ORDER];
      if (wr_xmode) wait_en <= reg_wdata[`ICC_XM_WAIT];
      if (wr_irqen) irq_en <= reg_wdata;
      if (wr_opmode) op_mode <= reg_wdata;
    end
  end

  // bit counter: a guarded write wins over the end-of-transfer clear
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      count <= `ICC_RST_COUNT;
    end else if (cnt_wr) begin
      count <= reg_wdata[`ICC_XM_CNT_HI:0];
    end else if (last_bit) begin
      count <= 3'h0;
    end
  end

  // pending conditions; a new write wins over the engine taking the old one
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      start_pend <= 1'b0;
      stop_pend  <= 1'b0;
    end else if (start_wr || stop_wr) begin
      start_pend <= start_wr;
      stop_pend  <= stop_wr;
    end else if (ctrl_rst || sync_fmt) begin
      start_pend <= 1'b0;
      stop_pend  <= 1'b0;
    end else begin
      if (next_state == ST_STA_A || next_state == ST_RS_A) start_pend <= 1'b0;
      if (next_state == ST_STO_A) stop_pend <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // engine registers
  // ---------------------------------------------------------------
  // the half period restarts on each state change, and while a slave stretches the clock
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      div   <= 16'h0;
      wcnt  <= 2'h0;
    end else begin
      state <= next_state;
      div   <= div_load ? 16'(HALF_CYC - 1) : div - 16'h1;
      wcnt  <= (state != ST_WAIT) ? 2'h0 : (tick ? wcnt + 2'h1 : wcnt);
    end
  end

  // bit counting and shifting; the acknowledge bit is counted but not shifted
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      left      <= 4'h0;
      sh        <= 8'h00;
      rx_byte   <= 8'h00;
      xfer_done <= 1'b0;
    end else begin
      xfer_done <= last_bit;
      if (ctrl_rst) begin
        left <= 4'h0;
      end else if (xfer_go && (state == ST_IDLE || state == ST_HOLD)) begin
        left <= count_total(sync_fmt, count);
        sh   <= tx_byte;
      end else if (bit_edge) begin
        left <= left_dec;
        if (!is_ack) sh <= next_sh;
        if (last_bit) rx_byte <= is_ack ? sh : next_sh;
      end
    end
  end

  // ---------------------------------------------------------------
  // pins and read data
  // ---------------------------------------------------------------
  // pins only ever pull low; the high level comes from the pull-ups
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      scl_o  <= 1'b0;
      sda_o  <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      scl_o  <= 1'b0;
      sda_o  <= 1'b0;
      scl_oe <= !scl_eng;
      sda_oe <= !(sda_eng && sda_val);
    end
  end

  // register read data, one cycle after the read strobe
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        // inhibit, guard and reserved bits read 1; levels are the driven ones
        `ICC_OFS_COND: reg_rdata <= {busy, 1'b1, !sda_oe, 1'b1, !scl_oe, 1'b1,
                                     ctrl_rst, 1'b1};
        `ICC_OFS_XMODE: reg_rdata <= {bit_order, wait_en, 2'b11, 1'b1, cnt_read};
        `ICC_OFS_IRQEN: reg_rdata <= irq_en;
        default: reg_rdata <= op_mode;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // interrupt requests
  // ---------------------------------------------------------------
  // plain levels: the flags' owners clear them, so nothing here is sticky
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= '0;
    end else begin
      irq.tx_empty_irq <= flags.tx_empty_flag && irq_en[`ICC_IE_TX_EMPTY];
      irq.tx_end_irq   <= flags.tx_end_flag && irq_en[`ICC_IE_TX_END];
      irq.rx_full_irq  <= flags.rx_full_flag && irq_en[`ICC_IE_RX_FULL];
      irq.overrun_irq  <= sync_fmt &&
                          ((flags.rx_full_flag && irq_en[`ICC_IE_RX_FULL]) ||
                           (flags.rx_lost_data_flag && irq_en[`ICC_IE_NACK]));
      irq.nack_irq     <= (flags.nack_flag || flags.arb_lost_flag) &&
                          irq_en[`ICC_IE_NACK];
    end
  end

endmodule
`default_nettype wire

/* icc_ctrl_monitor.sv */
// port checker for the bus control slice
`timescale 1ns/1ps
`default_nettype none
module icc_ctrl_monitor
  import icc_pkg::*;
(
  // clock and reset
  input wire logic       mclk,
  input wire logic       reset_n,
  // register port
  input wire logic [1:0] reg_addr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // requests and pins
  input wire icc_flags_s flags,
  input wire icc_irq_s   irq,
  input wire logic       scl_o,
  input wire logic       scl_oe,
  input wire logic       sda_o,
  input wire logic       sda_oe
);
  // ---------------------------------------------------------------
  // one clock domain, so clocking and reset are given once
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // read data may only appear in the slot after a read strobe
  property p_rdata_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
  // fixed ones in the condition word: inhibit, guard and reserved bits
  property p_cond_ones;
    $past(reg_rd) && $past(reg_addr) == 2'h0 |-> (reg_rdata & 8'h55) == 8'h55;
  endproperty
  a_cond_ones: assert property (p_cond_ones) else $error("condition word ones");
  property p_xm_ones;
    $past(reg_rd) && $past(reg_addr) == 2'h1 |-> reg_rdata[5:3] == 3'h7;
  endproperty
  a_xm_ones: assert property (p_xm_ones) else $error("mode word ones");
  // monitor bits follow the pin drive; stability guard avoids a sampling race
  property p_scl_mon;
    $past(reg_rd) && $past(reg_addr) == 2'h0 && $past(scl_oe, 2) == $past(scl_oe)
      |-> reg_rdata[3] == !$past(scl_oe);
  endproperty
  a_scl_mon: assert property (p_scl_mon) else $error("clock monitor bit");
  property p_sda_mon;
    $past(reg_rd) && $past(reg_addr) == 2'h0 && $past(sda_oe, 2) == $past(sda_oe)
      |-> reg_rdata[5] == !$past(sda_oe);
  endproperty
  a_sda_mon: assert property (p_sda_mon) else $error("data level bit");
  // open drain: the pins are only ever pulled low
  property p_od; scl_o == 1'b0 && sda_o == 1'b0; endproperty
  a_od: assert property (p_od) else $error("pin driven high");
  // a request needs its source flag one cycle before
  property p_txe; irq.tx_empty_irq |-> $past(flags.tx_empty_flag); endproperty
  a_txe: assert property (p_txe) else $error("tx empty request");
  property p_txend; irq.tx_end_irq |-> $past(flags.tx_end_flag); endproperty
  a_txend: assert property (p_txend) else $error("tx end request");
  property p_rxf; irq.rx_full_irq |-> $past(flags.rx_full_flag); endproperty
  a_rxf: assert property (p_rxf) else $error("rx full request");
  property p_nack;
    irq.nack_irq |-> $past(flags.nack_flag || flags.arb_lost_flag);
  endproperty
  a_nack: assert property (p_nack) else $error("nack request");
endmodule
bind icc_ctrl icc_ctrl_monitor u_mon (
  .mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .flags(flags), .irq(irq), .scl_o(scl_o),
  .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe)
);
`default_nettype wire

/* icc_ctrl_tb.sv */
// self-checking bench of the bus control slice
`timescale 1ns/1ps
`default_nettype none
module icc_ctrl_tb
  import icc_pkg::*;
;
  localparam int HC = 4;
  logic       mclk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, xfer_go = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00, tx_byte = 8'h00, rx_byte, reg_rdata;
  logic       xfer_done, scl_o, scl_oe, sda_o, sda_oe;
  wire logic  scl_i, sda_i;
  icc_flags_s flags = '0;
  icc_irq_s   irq;
  int         fails = 0, num_checks = 0;
  always #2 mclk = !mclk;
  icc_ctrl #(.HALF_CYC(HC)) uut (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .xfer_go(xfer_go), .tx_byte(tx_byte), .rx_byte(rx_byte), .xfer_done(xfer_done),
    .flags(flags), .irq(irq), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe));
  icc_bus_model bus (.scl_oe(scl_oe), .sda_oe(sda_oe), .scl_i(scl_i), .sda_i(sda_i));
  // ---------------------------------------------------------------
  // bus cycles and comparison
  // ---------------------------------------------------------------
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic rdchk(input string n, input logic [1:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    chk(n, v, e);
  endtask
  // busy follows the filtered pins a few cycles late, so poll it
  task automatic busy_is(input logic w);
    logic [7:0] v;
    for (int i = 0; i < 30; i++) begin
      rd(2'h0, v);
      if (v[7] === w) break;
    end
    chk("busy", {7'h0, v[7]}, {7'h0, w});
  endtask
  task automatic xfer(output int c, output int r, output logic [7:0] b);
    logic p;
    c = 0;
    r = 0;
    b = 8'h00;
    p = scl_i;
    @(posedge mclk);
    xfer_go <= 1'b1;
    @(posedge mclk);
    xfer_go <= 1'b0;
    while (xfer_done !== 1'b1 && c < 3000) begin
      @(posedge mclk) #1;
      c++;
      if (scl_i && !p && r++ < 8) b = {b[6:0], sda_i};
      p = scl_i;
    end
    chk("xfer done", {7'h0, xfer_done}, 8'h01);
  endtask
  task automatic bus_frame(input logic [7:0] xm, output int c, output int r,
                           output logic [7:0] b);
    wr(2'h0, 8'h90);
    busy_is(1'b1);
    for (int i = 0; i < 200 && scl_oe !== 1'b1; i++) @(posedge mclk);
    wr(2'h1, xm);
    xfer(c, r, b);
    wr(2'h0, 8'h10);
    busy_is(1'b0);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_guard();
    wr(2'h0, 8'h50);
    rdchk("sda guarded", 2'h0, 8'h7d);
    wr(2'h0, 8'h40);
    rdchk("sda low", 2'h0, 8'h5d);
    chk("sda_oe", {7'h0, sda_oe}, 8'h01);
    wr(2'h0, 8'h60);
    rdchk("sda high", 2'h0, 8'h7d);
    bus.scl_low = 1'b1;
    wr(2'h1, 8'h0d);
    rdchk("cnt guarded", 2'h1, 8'h38);
    wr(2'h1, 8'h05);
    rdchk("cnt", 2'h1, 8'h3d);
    wr(2'h1, 8'h00);
    bus.scl_low = 1'b0;
  endtask
  task automatic t_irq();
    logic [4:0] ex [6] = '{5'h10, 5'h08, 5'h04, 5'h01, 5'h01, 5'h00};
    wr(2'h2, 8'hf0);
    rdchk("irqen", 2'h2, 8'hf0);
    for (int i = 0; i < 6; i++) begin
      flags <= icc_flags_s'(6'h20 >> i);
      repeat (3) @(posedge mclk);
      #1 chk("irq", {3'h0, irq}, {3'h0, ex[i]});
    end
    flags <= '1;
    wr(2'h2, 8'h00);
    repeat (3) @(posedge mclk);
    #1 chk("irq masked", {3'h0, irq}, 8'h00);
    wr(2'h3, 8'h80);
    wr(2'h2, 8'hf0);
    flags <= icc_flags_s'(6'h08);
    repeat (3) @(posedge mclk);
    #1 chk("sync rx", {3'h0, irq}, 8'h06);
    flags <= icc_flags_s'(6'h01);
    repeat (3) @(posedge mclk);
    #1 chk("sync lost", {3'h0, irq}, 8'h02);
    flags <= '0;
    wr(2'h3, 8'h00);
  endtask
  task automatic t_busy();
    bus.start_cond();
    busy_is(1'b1);
    bus.stop_cond();
    busy_is(1'b0);
    wr(2'h3, 8'h80);
    bus.start_cond();
    repeat (20) @(posedge mclk);
    rdchk("sync busy", 2'h0, 8'h7d);
    bus.stop_cond();
    wr(2'h3, 8'h00);
  endtask
  task automatic t_master();
    int c0, r0, c1, r1, c2, r2;
    logic [7:0] b0, b1, b2;
    wr(2'h3, 8'h30);
    tx_byte <= 8'ha6;
    bus_frame(8'h07, c0, r0, b0);
    rdchk("cnt end", 2'h1, 8'h38);
    bus_frame(8'h47, c1, r1, b1);
    bus_frame(8'h00, c2, r2, b2);
    chk("bits cnt7", r0[7:0], 8'h08);
    chk("bits cnt0", r2[7:0], 8'h09);
    chk("wait gap", 8'(c1 - c0), 8'(4 * HC));
    chk("msb first", b2, 8'ha6);
    chk("rx byte", rx_byte, 8'ha6);
  endtask
  task automatic t_sync();
    int c0, r0, c1, r1;
    logic [7:0] b0, b1;
    wr(2'h3, 8'hb0);
    wr(2'h0, 8'h90);
    repeat (20) @(posedge mclk);
    #1 chk("no start", {7'h0, scl_oe}, 8'h00);
    wr(2'h1, 8'hc8);
    xfer(c0, r0, b0);
    wr(2'h1, 8'h08);
    xfer(c1, r1, b1);
    chk("sync bits", r0[7:0], 8'h08);
    chk("sync wait", 8'(c1), 8'(c0));
    chk("lsb first", b0, 8'h65);
    chk("sync msb", b1, 8'ha6);
  endtask
  task automatic t_ctrl_rst();
    logic seen;
    seen = 1'b0;
    @(posedge mclk);
    xfer_go <= 1'b1;
    @(posedge mclk);
    xfer_go <= 1'b0;
    repeat (10) @(posedge mclk);
    wr(2'h0, 8'h52);
    repeat (3) @(posedge mclk);
    repeat (4 * HC) @(posedge mclk) #1 seen = seen | scl_oe;
    chk("engine held", {7'h0, seen}, 8'h00);
    rdchk("ctrl rst", 2'h0, 8'h7f);
    rdchk("opmode kept", 2'h3, 8'hb0);
    wr(2'h0, 8'h50);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // reset, register reset values, then the scenarios in turn
  initial begin
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    rdchk("cond rst", 2'h0, 8'h7d);
    rdchk("xmode rst", 2'h1, 8'h38);
    rdchk("irqen rst", 2'h2, 8'h00);
    rdchk("opmode rst", 2'h3, 8'h00);
    t_guard();
    t_irq();
    t_busy();
    t_master();
    t_sync();
    t_ctrl_rst();
    end_of_test();
  end
  // the whole run needs well under this span
  initial begin
    #200000;
    fails++;
    end_of_test();
  end
endmodule
`default_nettype wire

/* icc_pkg.sv */
// types shared by the bus control slice
package icc_pkg;

  // engine states
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_STA_A = 4'h1,
    ST_STA_B = 4'h2,
    ST_HOLD  = 4'h3,
    ST_BIT_L = 4'h4,
    ST_BIT_H = 4'h5,
    ST_WAIT  = 4'h6,
    ST_RS_A  = 4'h7,
    ST_RS_B  = 4'h8,
    ST_STO_A = 4'h9,
    ST_STO_B = 4'ha,
    ST_SLAVE = 4'hb
  } icc_state_e;

  // status flags kept by the status logic outside this slice
  typedef struct packed {
    logic tx_empty_flag;
    logic tx_end_flag;
    logic rx_full_flag;
    logic nack_flag;
    logic arb_lost_flag;
    logic rx_lost_data_flag;
  } icc_flags_s;

  // interrupt request levels
  typedef struct packed {
    logic tx_empty_irq;
    logic tx_end_irq;
    logic rx_full_irq;
    logic overrun_irq;
    logic nack_irq;
  } icc_irq_s;

endpackage

/* icc_regs.svh */
// register offsets, field positions, reset values and timing counts of the bus control slice
`ifndef ICC_REGS_SVH
`define ICC_REGS_SVH

// ---------------------------------------------------------------
// register offsets (2-bit word address)
// ---------------------------------------------------------------
`define ICC_OFS_COND        2'h0
`define ICC_OFS_XMODE       2'h1
`define ICC_OFS_IRQEN       2'h2
`define ICC_OFS_OPMODE      2'h3

// ---------------------------------------------------------------
// bus_condition_ctrl fields
// ---------------------------------------------------------------
`define ICC_COND_BUSY       7
`define ICC_COND_INHIBIT    6
`define ICC_COND_SDA_VAL    5
`define ICC_COND_SDA_GUARD  4
`define ICC_COND_SCL_MON    3
`define ICC_COND_CTRL_RST   1

// ---------------------------------------------------------------
// transfer_mode fields
// ---------------------------------------------------------------
`define ICC_XM_ORDER        7
`define ICC_XM_WAIT         6
`define ICC_XM_CNT_GUARD    3
`define ICC_XM_CNT_HI       2

// ---------------------------------------------------------------
// irq_enable fields
// ---------------------------------------------------------------
`define ICC_IE_TX_EMPTY     7
`define ICC_IE_TX_END       6
`define ICC_IE_RX_FULL      5
`define ICC_IE_NACK         4

// ---------------------------------------------------------------
// op_mode fields
// ---------------------------------------------------------------
`define ICC_OM_SYNC_FMT     7
`define ICC_OM_MASTER       5
`define ICC_OM_TRANSMIT     4

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define ICC_RST_IRQEN       8'h00
`define ICC_RST_OPMODE      8'h00
`define ICC_RST_COUNT       3'h0
`define ICC_RST_SDA_VAL     1'b1

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define ICC_CLK_NS          4
`define ICC_SCL_HALF_NS     2000
`define ICC_SCL_HALF_CYC    ((`ICC_SCL_HALF_NS + `ICC_CLK_NS - 1) / `ICC_CLK_NS)
`define ICC_WAIT_HALVES     2'h3

`endif
